// [verilog/bto_pkg.sv]
// shared constants and types for the bit-invert / overflow-branch executor
package bto_pkg;

   // opcode patterns
   localparam logic [3:0] BTO_OPC_INVERT   = 4'h7;   // upper nibble of bit_invert_op
   localparam logic [7:0] BTO_OPC_BRANCH   = 8'he4;  // upper byte of branch_on_ovf_op

   // instruction field positions
   localparam int BTO_OPC_NIB_LSB = 12;
   localparam int BTO_BIT_LSB     = 9;
   localparam int BTO_ACC_POS     = 8;
   localparam int BTO_OPC_BYTE_LSB = 8;

   // addressing constants
   localparam logic [7:0] BTO_IDX_LIMIT    = 8'h5f;  // indexed literal offset ceiling (95)
   localparam logic [7:0] BTO_ACCESS_SPLIT = 8'h60;  // low access bank ends below this
   localparam logic [3:0] BTO_SFR_BANK     = 4'hf;   // upper access bank maps to last bank

   // program counter step per program word
   localparam logic [2:0] BTO_PC_STEP      = 3'h2;

   // quarter phases of one instruction cycle
   typedef enum logic [1:0] {BTO_Q1, BTO_Q2, BTO_Q3, BTO_Q4} bto_phase_e;

   // decoded operation
   typedef enum logic [1:0] {BTO_OP_NONE, BTO_OP_INVERT, BTO_OP_BRANCH} bto_op_e;

endpackage : bto_pkg

// [verilog/bto_decode.sv]
// opcode decoder for bit_invert_op and branch_on_ovf_op
`timescale 1ns/1ps
module bto_decode
   import bto_pkg::*;
(
   // instruction word
   input  wire logic [15:0] instr,
   // decoded fields
   output bto_op_e          op,
   output logic [2:0]       bit_idx,
   output logic             acc_sel,
   output logic [7:0]       file_addr,
   output logic [7:0]       offset
);

   // pure field split, no state
   always_comb
   begin
      bit_idx   = instr[BTO_BIT_LSB +: 3];
      acc_sel   = instr[BTO_ACC_POS];
      file_addr = instr[7:0];
      offset    = instr[7:0];
      if (instr[BTO_OPC_NIB_LSB +: 4] == BTO_OPC_INVERT)           // see RULE1
         op = BTO_OP_INVERT;
      else if (instr[BTO_OPC_BYTE_LSB +: 8] == BTO_OPC_BRANCH)     // see RULE7
         op = BTO_OP_BRANCH;
      else
         op = BTO_OP_NONE;
   end

endmodule : bto_decode

// [verilog/bto_addr_gen.sv]
// data memory address former for byte-oriented operands
`timescale 1ns/1ps
module bto_addr_gen
   import bto_pkg::*;
#(
   parameter int BANK_W = 4
)
(
   // operand inputs
   input  wire logic [7:0]          file_addr,
   input  wire logic                acc_sel,
   input  wire logic                ext_en,
   input  wire logic [BANK_W-1:0]   bank_sel,
   input  wire logic [BANK_W+7:0]   idx_base,
   // formed address
   output logic      [BANK_W+7:0]   addr
);

   // access bank, indexed literal offset or banked region
   always_comb
   begin
      if (acc_sel)
         addr = {bank_sel, file_addr};                                  // see RULE4
      else if (ext_en && (file_addr <= BTO_IDX_LIMIT))
         addr = idx_base + {{BANK_W{1'b0}}, file_addr};                 // see RULE5
      else if (file_addr < BTO_ACCESS_SPLIT)
         addr = {{BANK_W{1'b0}}, file_addr};                            // see RULE3
      else
         addr = {{(BANK_W-4){1'b1}}, BTO_SFR_BANK, file_addr};          // see RULE3
   end

endmodule : bto_addr_gen

// [verilog/bto_core.sv]
// execution core for bit_invert_op and branch_on_ovf_op in four quarter phases
//
// Summary of operation
// RULE1: opcode 0111 bbba ffff ffff inverts a bit
// RULE2: invert one bit, all else and flags kept
// RULE3: access selector clear uses the access bank
// RULE4: access selector set uses bank select register
// RULE5: extended set, selector clear, f<=95: indexed
// RULE6: bit invert: one word, one cycle, Q1..Q4
// RULE7: opcode 1110 0100 nnnn branches on overflow
// RULE8: branch only when overflow flag is one
// RULE9: taken target is old address+2+2n
// RULE10: branch one cycle, two when taken
// RULE11: taken writes program_counter in Q4, else none
// RULE12: bit index 0 selects least significant bit
`timescale 1ns/1ps
module bto_core
   import bto_pkg::*;
#(
   parameter int BANK_W = 4,
   parameter int PC_W   = 21
)
(
   // clock and reset
   input  wire logic                CORE_CLK,
   input  wire logic                NRST,
   // instruction stream, word at PROGRAM_COUNTER, sampled in Q1
   input  wire logic [15:0]         INSTR,
   // core state inputs
   input  wire logic                OVF_FLAG,
   input  wire logic                EXT_EN,
   input  wire logic [BANK_W-1:0]   BANK_SELECT_REGISTER,
   input  wire logic [BANK_W+7:0]   IDX_BASE,
   // data memory port
   output logic      [BANK_W+7:0]   MEM_ADDR,
   output logic                     MEM_RD,
   input  wire logic [7:0]          MEM_RDATA,
   output logic                     MEM_WR,
   output logic      [7:0]          MEM_WDATA,
   // program counter and sequencing
   output logic      [PC_W-1:0]     PROGRAM_COUNTER,
   output logic                     PC_LOAD,
   output logic                     FLUSH,
   output logic      [1:0]          Q_PHASE
);

   // decoder and address former outputs
   bto_op_e                dec_op;
   logic [2:0]             dec_bit;
   logic                   dec_acc;
   logic [7:0]             dec_file;
   logic [7:0]             dec_off;
   logic [BANK_W+7:0]      dec_addr;

   bto_decode u_decode
   (
      .instr     (INSTR),
      .op        (dec_op),
      .bit_idx   (dec_bit),
      .acc_sel   (dec_acc),
      .file_addr (dec_file),
      .offset    (dec_off)
   );

   bto_addr_gen #(.BANK_W(BANK_W)) u_addr
   (
      .file_addr (dec_file),
      .acc_sel   (dec_acc),
      .ext_en    (EXT_EN),
      .bank_sel  (BANK_SELECT_REGISTER),
      .idx_base  (IDX_BASE),
      .addr      (dec_addr)
   );

   // sequencing state
   bto_phase_e             q;
   bto_phase_e             next_q;
   logic                   flush;
   logic                   next_flush;
   bto_op_e                op;
   bto_op_e                next_op;
   logic [2:0]             bit_sel;
   logic [2:0]             next_bit_sel;
   logic [7:0]             off;
   logic [7:0]             next_off;
   logic                   taken;
   logic                   next_taken;

   // datapath and output state
   logic [BANK_W+7:0]      mem_addr;
   logic [BANK_W+7:0]      next_mem_addr;
   logic                   mem_rd;
   logic                   next_mem_rd;
   logic                   mem_wr;
   logic                   next_mem_wr;
   logic [7:0]             mem_wdata;
   logic [7:0]             next_mem_wdata;
   logic [PC_W-1:0]        pc;
   logic [PC_W-1:0]        next_pc;
   logic                   pc_load;
   logic                   next_pc_load;

   // twice the signed offset, sign extended to the counter width
   logic [PC_W-1:0]        disp;
   assign disp = {{(PC_W-9){off[7]}}, off, 1'b0};                 // see RULE9

   // phase walker and instruction capture
   always_comb
   begin
      next_flush   = flush;
      next_op      = op;
      next_bit_sel = bit_sel;
      next_off     = off;
      next_taken   = taken;
      unique case (q)
         BTO_Q1:
         begin
            next_q = BTO_Q2;
            // a flushed cycle ignores the fetched word entirely
            if (flush)
            begin
               next_op    = BTO_OP_NONE;                           // see RULE10
               next_taken = 1'b0;
            end
            else
            begin
               next_op      = dec_op;
               next_bit_sel = dec_bit;
               next_off     = dec_off;
               next_taken   = (dec_op == BTO_OP_BRANCH) && OVF_FLAG;  // see RULE8
            end
         end
         BTO_Q2:
            next_q = BTO_Q3;
         BTO_Q3:
            next_q = BTO_Q4;
         BTO_Q4:
         begin
            next_q = BTO_Q1;
            // a taken branch costs one dead cycle while fetch refills
            next_flush = taken;                                    // see RULE10
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         q       <= BTO_Q1;
         flush   <= 1'b0;
         op      <= BTO_OP_NONE;
         bit_sel <= 3'h0;
         off     <= 8'h00;
         taken   <= 1'b0;
      end
      else
      begin
         q       <= next_q;
         flush   <= next_flush;
         op      <= next_op;
         bit_sel <= next_bit_sel;
         off     <= next_off;
         taken   <= next_taken;
      end
   end

   // memory read in Q2, modify in Q3, write back in Q4
   always_comb
   begin
      next_mem_addr  = mem_addr;
      next_mem_rd    = 1'b0;
      next_mem_wr    = 1'b0;
      next_mem_wdata = mem_wdata;
      if ((q == BTO_Q1) && !flush && (dec_op == BTO_OP_INVERT))
      begin
         next_mem_addr = dec_addr;
         next_mem_rd   = 1'b1;                                     // see RULE6
      end
      if ((q == BTO_Q3) && (op == BTO_OP_INVERT))
      begin
         // only the chosen bit flips; flags are never touched here
         next_mem_wdata = MEM_RDATA ^ (8'h01 << bit_sel);          // see RULE2, see RULE12
         next_mem_wr    = 1'b1;                                    // see RULE6
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         mem_addr  <= '0;
         mem_rd    <= 1'b0;
         mem_wr    <= 1'b0;
         mem_wdata <= 8'h00;
      end
      else
      begin
         mem_addr  <= next_mem_addr;
         mem_rd    <= next_mem_rd;
         mem_wr    <= next_mem_wr;
         mem_wdata <= next_mem_wdata;
      end
   end

   // program counter: branch target shown in Q4, dead cycle holds, else plain step at cycle end
   always_comb
   begin
      next_pc      = pc;
      next_pc_load = 1'b0;
      if ((q == BTO_Q3) && taken)
      begin
         next_pc      = pc + PC_W'(BTO_PC_STEP) + disp;            // see RULE9, see RULE11
         next_pc_load = 1'b1;                                      // see RULE11
      end
      // the dead cycle refetches at the target, so it must not step past it
      else if ((q == BTO_Q4) && !taken && !flush)
         next_pc = pc + PC_W'(BTO_PC_STEP);                        // see RULE8
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         pc      <= '0;
         pc_load <= 1'b0;
      end
      else
      begin
         pc      <= next_pc;
         pc_load <= next_pc_load;
      end
   end

   // outputs straight from flops
   assign MEM_ADDR        = mem_addr;
   assign MEM_RD          = mem_rd;
   assign MEM_WR          = mem_wr;
   assign MEM_WDATA       = mem_wdata;
   assign PROGRAM_COUNTER = pc;
   assign PC_LOAD         = pc_load;
   assign FLUSH           = flush;
   assign Q_PHASE         = q;

   // the read is always in Q2 of a bit-invert cycle
   chk_read_in_q2: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE6
      mem_rd |-> (q == BTO_Q2) && (op == BTO_OP_INVERT))
      else $error("memory read outside Q2 of bit invert");

   // write follows read by exactly two clocks at the same address
   chk_write_after: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE6
      mem_rd |-> ##2 (mem_wr && (mem_addr == $past(mem_addr, 2))))
      else $error("write back not two clocks after read");

   // written byte differs from read byte in exactly the chosen bit
   chk_single_flip: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE2
      mem_wr |-> ((mem_wdata ^ $past(MEM_RDATA)) == (8'h01 << bit_sel)))
      else $error("bit invert changed wrong bits");

   // opcode 0111 starts a read in the next clock
   chk_invert_decode: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE1
      ((q == BTO_Q1) && !flush && (INSTR[15:12] == 4'h7)) |=> mem_rd)
      else $error("bit invert opcode not executed");

   // taken branch lands on old address plus 2 plus twice the offset
   chk_branch_target: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE9
      pc_load |-> (pc == $past(pc) + PC_W'(2) + disp))
      else $error("branch target wrong");

   // counter is written only in Q4 of a taken branch
   chk_load_phase: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE11
      pc_load |-> (q == BTO_Q4) && taken && (op == BTO_OP_BRANCH))
      else $error("program counter load outside taken Q4");

   // untaken branch and plain cycles just step by two in four clocks
   chk_seq_step: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE8
      ((q == BTO_Q1) && !flush && !((dec_op == BTO_OP_BRANCH) && OVF_FLAG))
      |-> ##4 (pc == $past(pc, 4) + PC_W'(2)))
      else $error("sequential step wrong");

   // a taken branch is followed by one whole dead cycle
   chk_flush_cycle: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE10
      pc_load |=> flush [*4] ##1 !flush)
      else $error("flush cycle length wrong");

   // a flushed cycle touches no memory and raises no pc_load in Q3
   chk_flush_quiet: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE10
      (flush && (q == BTO_Q1)) |=> !mem_rd ##1 (!mem_wr && !pc_load) ##1 !mem_wr)
      else $error("flushed cycle was not idle");

   // the dead cycle leaves the counter on the branch target
   chk_dead_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE10
      (flush && (q == BTO_Q4)) |=> $stable(pc))
      else $error("counter moved in dead cycle");

   // indexed literal offset used when extended and low address
   chk_indexed_addr: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE5
      ((q == BTO_Q1) && !flush && (dec_op == BTO_OP_INVERT) && EXT_EN && !INSTR[8]
       && (INSTR[7:0] <= 8'h5f))
      |=> (mem_addr == $past(IDX_BASE) + {{BANK_W{1'b0}}, $past(INSTR[7:0])}))
      else $error("indexed literal address wrong");

   // banked access takes its bank from the bank select register
   chk_banked_addr: assert property (@(posedge CORE_CLK) disable iff (!NRST) // see RULE4
      ((q == BTO_Q1) && !flush && (dec_op == BTO_OP_INVERT) && INSTR[8])
      |=> (mem_addr == {$past(BANK_SELECT_REGISTER), $past(INSTR[7:0])}))
      else $error("banked address wrong");

endmodule : bto_core

// [testbench/tb_top.sv]
// self-checking bench for the bit-invert / overflow-branch core
`timescale 1ns/1ps
module tb_top;
   // stimulus
   logic        CORE_CLK = 0;
   logic        NRST = 0;
   logic [15:0] INSTR = 0;
   logic        OVF_FLAG = 0;
   logic        EXT_EN = 0;
   logic [3:0]  BANK_SELECT_REGISTER = 0;
   logic [11:0] IDX_BASE = 0;
   logic [7:0]  MEM_RDATA = 0;
   // observed
   logic [11:0] MEM_ADDR;
   logic        MEM_RD;
   logic        MEM_WR;
   logic [7:0]  MEM_WDATA;
   logic [20:0] PROGRAM_COUNTER;
   logic        PC_LOAD;
   logic        FLUSH;
   logic [1:0]  Q_PHASE;
   // model state
   int          mismatches = 0;
   int          cmp_count = 0;
   logic [31:0] seed = 32'd11506;
   logic [7:0]  mem [4096];
   logic [20:0] exp_pc = 0;
   logic [7:0]  ftab [4] = '{8'h00, 8'h5f, 8'h60, 8'hff};
   logic [7:0]  ntab [5] = '{8'h80, 8'h7f, 8'h00, 8'hff, 8'h01};

   // 100 MHz core clock
   always #5 CORE_CLK = ~CORE_CLK;

   bto_core u_dut (.CORE_CLK, .NRST, .INSTR, .OVF_FLAG, .EXT_EN, .BANK_SELECT_REGISTER,
      .IDX_BASE, .MEM_ADDR, .MEM_RD, .MEM_RDATA, .MEM_WR, .MEM_WDATA, .PROGRAM_COUNTER,
      .PC_LOAD, .FLUSH, .Q_PHASE);

   // xorshift source, fixed seed
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // inputs change 1 ns after the rising edge
   task automatic tick();
      @(posedge CORE_CLK);
      #1;
   endtask : tick

   // bounded wait for a live Q1
   task automatic wait_q1();
      int i;
      for (i = 0; i < 20 && !(Q_PHASE === 2'h0 && FLUSH === 1'b0); i++)
         tick();
      if (i == 20)
      begin
         mismatches++;
         wrap_up();
      end
   endtask : wait_q1

   // expected data address from the live operand state
   function automatic logic [11:0] addr_of(logic [7:0] f, logic a);
      if (a)
         return {BANK_SELECT_REGISTER, f};
      if (EXT_EN && f <= 8'h5f)
         return IDX_BASE + 12'(f);
      return (f < 8'h60) ? {4'h0, f} : {4'hf, f};
   endfunction : addr_of

   // one instruction word through all its quarters
   task automatic exec(input logic [15:0] w, input logic ovf);
      logic [11:0] ad;
      logic [7:0]  rd;
      logic        inv;
      logic        tk;
      logic [20:0] old;
      wait_q1();
      INSTR = w;
      OVF_FLAG = ovf;
      {EXT_EN, BANK_SELECT_REGISTER, IDX_BASE} = 17'(rnd());
      inv = (w[15:12] == 4'h7);
      tk = (w[15:8] == 8'he4) && ovf;
      ad = addr_of(w[7:0], w[8]);
      rd = mem[ad];
      old = exp_pc;
      tick();
      // scramble the word: only the Q1 sample may count
      {INSTR, OVF_FLAG} = 17'(rnd());
      chk("mem_rd", MEM_RD, inv);
      if (inv)
         chk("mem_addr", MEM_ADDR, ad);
      tick();
      if (inv)
         MEM_RDATA = rd;
      tick();
      MEM_RDATA = ~MEM_RDATA; // released bus shows no stale data
      chk("mem_wr", MEM_WR, inv);
      if (inv)
      begin
         rd[w[11:9]] = ~rd[w[11:9]];
         chk("mem_wdata", MEM_WDATA, rd);
         mem[ad] = rd;
      end
      exp_pc += 21'h2;
      if (tk)
         exp_pc += {{12{w[7]}}, w[7:0], 1'b0};
      chk("pc_load", PC_LOAD, tk);
      chk("pc_q4", PROGRAM_COUNTER, tk ? exp_pc : old);
      tick();
      chk("flush", FLUSH, tk);
      chk("pc_next", PROGRAM_COUNTER, exp_pc);
      chk("q_phase", Q_PHASE, 2'h0);
      if (tk)
      begin
         repeat (3)
         begin
            tick();
            chk("dead", {MEM_RD, MEM_WR, PC_LOAD, FLUSH}, 4'h1);
         end
         tick();
         chk("flush_end", FLUSH, 1'b0);
         chk("pc_dead", PROGRAM_COUNTER, exp_pc);
      end
   endtask : exec

   // main sequence
   initial
   begin
      logic [31:0] r;
      foreach (mem[i])
         mem[i] = 8'(rnd());
      repeat (6) tick();
      chk("rst_pc", PROGRAM_COUNTER, 21'h0);
      chk("rst_out", {MEM_RD, MEM_WR, PC_LOAD, FLUSH, Q_PHASE}, 6'h0);
      NRST = 1;
      // every bit index, both selectors, boundary addresses
      for (int b = 0; b < 16; b++)
         exec({4'h7, 4'(b), ftab[b % 4]}, 1'b0);
      exec(16'h7e80, 1'b1); // back to back on one byte
      exec(16'h7e80, 1'b1);
      // extreme offsets, overflow clear and set
      for (int k = 0; k < 10; k++)
         exec({8'he4, ntab[k % 5]}, k >= 5);
      // mixed random traffic, unknown opcodes included
      repeat (150)
      begin
         r = rnd();
         case (r[1:0])
            2'h0: exec({4'h7, r[27:16]}, r[2]);
            2'h1: exec({8'he4, r[23:16]}, r[2]);
            default: exec(r[31:16], r[2]);
         endcase
      end
      // reset in the middle of a bit invert
      wait_q1();
      INSTR = 16'h7000;
      tick();
      NRST = 0;
      #1;
      chk("mid_rst", {MEM_RD, PROGRAM_COUNTER, Q_PHASE}, 24'h0);
      tick();
      NRST = 1;
      exp_pc = 0;
      repeat (20) exec(16'(rnd()), 1'b1);
      wrap_up();
   end
endmodule : tb_top
